//--- shared/led_strobe_pkg.sv
// Purpose: Constants for the strobe-programmed LED driver and charge pump control.
// Assumes: 125 MHz system clock.
// Notes: Times are kept in their own units; cycle counts are derived from them.
package led_strobe_pkg;
    localparam int CLK_KHZ = 125000;
    localparam int LATCH_US = 150;
    localparam int LATCH_CYC = LATCH_US * CLK_KHZ / 1000;
    localparam int REF_US = 100;
    localparam int REF_CYC = REF_US * CLK_KHZ / 1000;
    localparam int SWITCH_US = 400;
    localparam int SWITCH_CYC = SWITCH_US * CLK_KHZ / 1000;
    localparam int RAMP_US = 150;
    localparam int RAMP_CYC = RAMP_US * CLK_KHZ / 1000;
    localparam int PUMP_KHZ = 800;
    localparam int HALF_CYC = CLK_KHZ / (2 * PUMP_KHZ);
    localparam int NONOV_CYC = 4;
    localparam int MAIN_W = 6;
    localparam int CAM_W = 3;
    localparam int RAMP_W = 8;
    localparam logic [MAIN_W-1:0] MAIN_FS = 6'h3f;
    localparam logic [MAIN_W-1:0] MAIN_LSB = 6'h01;
    localparam logic [CAM_W-1:0] CAM_FS = 3'h7;
    localparam logic [CAM_W-1:0] CAM_LSB = 3'h1;
    localparam int TMR_W = 16;
    typedef enum logic [2:0] {
        PUMP_X1 = 3'b001,
        PUMP_X15 = 3'b010,
        PUMP_X2 = 3'b100
    } pump_mode_t;
endpackage

//--- src/led_strobe_dac_pump_ctrl.sv
// Purpose: Strobe decoding, current DAC codes, shutdown and charge pump mode control.
// Assumes: Strobe, dropout and sense inputs are synchronous to clk.
// Notes: Analog regulation is outside; this block drives codes, enables and switch phases.
//
// What this block does
// - Main strobe rising edge decrements 6-bit counter.
// - Camera strobe rising edge decrements 3-bit counter.
// - Counters saturate at one LSB.
// - Value applied 150 us after strobe held high.
// - Strobe held low zeroes channel current.
// - Resume within 150 us continues; else counter resets.
// - Both low past 150 us enters shutdown.
// - Camera falling edge or shutdown forces 1x.
// - Start 1x; dropout advances to 1.5x.
// - Further dropout in 1.5x advances to 2x.
// - Two-phase nonoverlapping pump clock at 800 kHz.
// - Same two-phase pattern in 1.5x and 2x modes; no switching in 1x.
// - Ramp pump current over 150 us on upshift.
// - Enable after shutdown takes 100 us longer.
// - Main sink tied to pump output is disabled.
// - Low programming resistor forces overcurrent shutdown.
// - Wait 0.4 ms from dropout to mode change.
// - First edge gives full scale, then steps down.
`timescale 1ns/1ps
module led_strobe_dac_pump_ctrl
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic mainStrobeIn,
    input wire logic camStrobeIn,
    input wire logic [3:0] mainSinkDropout,
    input wire logic camSinkDropout,
    input wire logic [3:0] mainSinkTiedToPump,
    input wire logic mainSetResistorLow,
    input wire logic camSetResistorLow,
    output logic [led_strobe_pkg::MAIN_W-1:0] mainDacCode,
    output logic [led_strobe_pkg::CAM_W-1:0] camDacCode,
    output logic [3:0] mainLedSinksEn,
    output logic camLedSinkEn,
    output logic pumpEn,
    output logic refEn,
    output logic shutdown,
    output logic overcurrent,
    output led_strobe_pkg::pump_mode_t pumpMode,
    output logic pumpPhase1,
    output logic pumpPhase2,
    output logic [led_strobe_pkg::RAMP_W-1:0] pumpStrength
);
    import led_strobe_pkg::*;

    // ----------------------------------------------------------------
    // Strobe edges and interval timers
    // ----------------------------------------------------------------
    logic mainPrev_ff, camPrev_ff, nxt_mainPrev, nxt_camPrev;
    logic [TMR_W-1:0] mainTmr_ff, camTmr_ff, nxt_mainTmr, nxt_camTmr;
    logic [MAIN_W-1:0] mainCnt_ff, nxt_mainCnt;
    logic [CAM_W-1:0] camCnt_ff, nxt_camCnt;
    logic [MAIN_W-1:0] nxt_mainDac;
    logic [CAM_W-1:0] nxt_camDac;
    logic shutdown_ff, nxt_shutdown;
    logic [TMR_W-1:0] refTmr_ff, nxt_refTmr;
    logic mainRise, camRise, camFall, mainSettled, camSettled;

    always_comb
    begin
        // Edge detectors reset low, the idle strobe level, so reset leaves no false edge.
        mainRise = mainStrobeIn & ~mainPrev_ff;
        camRise = camStrobeIn & ~camPrev_ff;
        camFall = ~camStrobeIn & camPrev_ff;
        nxt_mainPrev = mainStrobeIn;
        nxt_camPrev = camStrobeIn;
        // Timers restart on any edge and saturate at the interval.
        nxt_mainTmr = mainTmr_ff;
        if (mainStrobeIn != mainPrev_ff)
            nxt_mainTmr = '0;
        else if (mainTmr_ff < TMR_W'(LATCH_CYC))
            nxt_mainTmr = mainTmr_ff + 1'b1;
        nxt_camTmr = camTmr_ff;
        if (camStrobeIn != camPrev_ff)
            nxt_camTmr = '0;
        else if (camTmr_ff < TMR_W'(LATCH_CYC))
            nxt_camTmr = camTmr_ff + 1'b1;
        mainSettled = mainTmr_ff == TMR_W'(LATCH_CYC);
        camSettled = camTmr_ff == TMR_W'(LATCH_CYC);

        // A rise on a cleared counter loads full scale; the count wraps only from zero.
        nxt_mainCnt = mainCnt_ff;
        if (mainRise)
        begin
            if (mainCnt_ff == '0)
                nxt_mainCnt = MAIN_FS;
            else if (mainCnt_ff != MAIN_LSB)
                nxt_mainCnt = mainCnt_ff - 1'b1;
        end
        else if (!mainStrobeIn && mainSettled)
            nxt_mainCnt = '0;
        nxt_camCnt = camCnt_ff;
        if (camRise)
        begin
            if (camCnt_ff == '0)
                nxt_camCnt = CAM_FS;
            else if (camCnt_ff != CAM_LSB)
                nxt_camCnt = camCnt_ff - 1'b1;
        end
        else if (!camStrobeIn && camSettled)
            nxt_camCnt = '0;

        // Held-low strobe drops the current at once; held-high latches after the interval.
        // The latch also waits for the reference, so a first enable sits out its start-up.
        nxt_mainDac = mainDacCode;
        if (!mainStrobeIn)
            nxt_mainDac = '0;
        else if (mainSettled && refTmr_ff == '0)
            nxt_mainDac = mainCnt_ff;
        nxt_camDac = camDacCode;
        if (!camStrobeIn)
            nxt_camDac = '0;
        else if (camSettled && refTmr_ff == '0)
            nxt_camDac = camCnt_ff;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mainPrev_ff <= 1'b0;
            camPrev_ff <= 1'b0;
            mainTmr_ff <= '0;
            camTmr_ff <= '0;
            mainCnt_ff <= '0;
            camCnt_ff <= '0;
            mainDacCode <= '0;
            camDacCode <= '0;
        end
        else
        begin
            mainPrev_ff <= nxt_mainPrev;
            camPrev_ff <= nxt_camPrev;
            mainTmr_ff <= nxt_mainTmr;
            camTmr_ff <= nxt_camTmr;
            mainCnt_ff <= nxt_mainCnt;
            camCnt_ff <= nxt_camCnt;
            mainDacCode <= nxt_mainDac;
            camDacCode <= nxt_camDac;
        end
    end

    // ----------------------------------------------------------------
    // Shutdown and reference start-up
    // ----------------------------------------------------------------
    logic settledHigh;

    always_comb
    begin
        settledHigh = (mainStrobeIn && mainSettled) || (camStrobeIn && camSettled);
        // A low set resistor wins over any strobe, so a fault cannot be strobed away.
        nxt_shutdown = shutdown_ff;
        if (mainSetResistorLow || camSetResistorLow)
            nxt_shutdown = 1'b1;
        else if (!mainStrobeIn && !camStrobeIn && mainSettled && camSettled)
            nxt_shutdown = 1'b1;
        else if (mainStrobeIn || camStrobeIn)
            nxt_shutdown = 1'b0;

        // The reference wait only counts once a channel has settled high, so the first
        // enable after shutdown lands that much later than a normal one.
        nxt_refTmr = refTmr_ff;
        if (shutdown_ff && !nxt_shutdown)
            nxt_refTmr = TMR_W'(REF_CYC);
        else if (refTmr_ff != '0 && settledHigh)
            nxt_refTmr = refTmr_ff - 1'b1;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            shutdown_ff <= 1'b1;
            refTmr_ff <= '0;
        end
        else
        begin
            shutdown_ff <= nxt_shutdown;
            refTmr_ff <= nxt_refTmr;
        end
    end

    // ----------------------------------------------------------------
    // Charge pump mode machine and soft-start ramp
    // ----------------------------------------------------------------
    pump_mode_t mode_ff, nxt_mode;
    logic [TMR_W-1:0] dropTmr_ff, nxt_dropTmr;
    logic [TMR_W-1:0] rampTmr_ff, nxt_rampTmr;
    logic [RAMP_W-1:0] nxt_strength;
    logic dropout;

    always_comb
    begin
        // Only sinks that carry current can report dropout.
        dropout = (|(mainSinkDropout & mainLedSinksEn)) | (camSinkDropout & camLedSinkEn);
        nxt_mode = mode_ff;
        // Dropout must persist unbroken for the whole wait; one clean cycle restarts it.
        nxt_dropTmr = '0;
        nxt_rampTmr = rampTmr_ff;
        // A camera falling edge drops to 1x even mid-wait and restarts the dropout count.
        if (shutdown_ff || camFall)
            nxt_mode = PUMP_X1;
        else if (dropout && mode_ff != PUMP_X2)
        begin
            nxt_dropTmr = dropTmr_ff + 1'b1;
            if (dropTmr_ff == TMR_W'(SWITCH_CYC - 1))
            begin
                nxt_dropTmr = '0;
                nxt_rampTmr = '0;
                case (mode_ff)
                    PUMP_X1: nxt_mode = PUMP_X15;
                    PUMP_X15: nxt_mode = PUMP_X2;
                    default: nxt_mode = mode_ff;
                endcase
            end
        end
        if (nxt_mode == mode_ff && rampTmr_ff < TMR_W'(RAMP_CYC))
            nxt_rampTmr = rampTmr_ff + 1'b1;
        // Strength ramps linearly from zero to full over the ramp interval.
        // Strength follows the next mode, so a step never shows full strength for a cycle.
        nxt_strength = RAMP_W'((32'(nxt_rampTmr) * 255) / RAMP_CYC);
        if (nxt_mode == PUMP_X1)
            nxt_strength = '1;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mode_ff <= PUMP_X1;
            dropTmr_ff <= '0;
            rampTmr_ff <= '0;
            pumpStrength <= '0;
        end
        else
        begin
            mode_ff <= nxt_mode;
            dropTmr_ff <= nxt_dropTmr;
            rampTmr_ff <= nxt_rampTmr;
            pumpStrength <= nxt_strength;
        end
    end

    // ----------------------------------------------------------------
    // Two-phase nonoverlapping pump clock
    // ----------------------------------------------------------------
    logic [7:0] divCnt_ff, nxt_divCnt;
    logic half_ff, nxt_half;
    logic nxt_ph1, nxt_ph2, active;

    always_comb
    begin
        // Free-running divider keeps the frequency constant in every mode.
        nxt_divCnt = divCnt_ff + 1'b1;
        nxt_half = half_ff;
        if (divCnt_ff == 8'(HALF_CYC - 1))
        begin
            nxt_divCnt = '0;
            nxt_half = ~half_ff;
        end
        // The divider never stops, so the first phase after a mode step may come out short.
        active = !shutdown_ff && mode_ff != PUMP_X1;
        // Both phases drop for a short gap after each toggle, so switches never overlap.
        nxt_ph1 = active && !half_ff && divCnt_ff >= 8'(NONOV_CYC);
        nxt_ph2 = active && half_ff && divCnt_ff >= 8'(NONOV_CYC);
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            divCnt_ff <= '0;
            half_ff <= 1'b0;
            pumpPhase1 <= 1'b0;
            pumpPhase2 <= 1'b0;
        end
        else
        begin
            divCnt_ff <= nxt_divCnt;
            half_ff <= nxt_half;
            pumpPhase1 <= nxt_ph1;
            pumpPhase2 <= nxt_ph2;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_comb
    begin
        pumpMode = mode_ff;
        shutdown = shutdown_ff;
        // Overcurrent is shown straight from the sense inputs, a cycle ahead of shutdown.
        overcurrent = mainSetResistorLow | camSetResistorLow;
        pumpEn = !shutdown_ff;
        refEn = !shutdown_ff;
        mainLedSinksEn = {4{!shutdown_ff && mainDacCode != '0}} & ~mainSinkTiedToPump;
        camLedSinkEn = !shutdown_ff && camDacCode != '0;
    end
endmodule

//--- bench/led_strobe_properties.sv
// Purpose: Port-level checks for the strobe DAC and charge pump control.
// Assumes: One clock domain with an active-high reset.
// Notes: The dropout counter bounds how early a mode step may come.
`timescale 1ns/1ps
module led_strobe_properties
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic mainStrobeIn,
    input wire logic camStrobeIn,
    input wire logic [3:0] mainSinkDropout,
    input wire logic camSinkDropout,
    input wire logic [3:0] mainSinkTiedToPump,
    input wire logic mainSetResistorLow,
    input wire logic camSetResistorLow,
    input wire logic [led_strobe_pkg::MAIN_W-1:0] mainDacCode,
    input wire logic [3:0] mainLedSinksEn,
    input wire logic shutdown,
    input wire logic overcurrent,
    input wire led_strobe_pkg::pump_mode_t pumpMode,
    input wire logic pumpPhase1,
    input wire logic pumpPhase2
);
    import led_strobe_pkg::*;
    // ------------------------------------------------------------
    // Helper counter and assertions
    // ------------------------------------------------------------
    int dropCnt_ff;
    int nxt_dropCnt;
    always_comb
    begin
        nxt_dropCnt = (|mainSinkDropout || camSinkDropout) ? dropCnt_ff + 1 : 0;
    end
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            dropCnt_ff <= 0;
        else
            dropCnt_ff <= nxt_dropCnt;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_x1_held;
        (pumpMode == PUMP_X1) [*2];
    endsequence
    a_overcurrent_flag: assert property (overcurrent == (mainSetResistorLow || camSetResistorLow))
        else $error("overcurrent flag wrong");
    a_phase_gap: assert property (!(pumpPhase1 && pumpPhase2))
        else $error("pump phases overlap");
    a_phase_idle: assert property (s_x1_held |-> !pumpPhase1 && !pumpPhase2)
        else $error("pump switching in 1x");
    a_main_sinks: assert property (mainLedSinksEn ==
        ({4{!shutdown && mainDacCode != '0}} & ~mainSinkTiedToPump))
        else $error("main sink enables wrong");
    a_low_clears: assert property (!mainStrobeIn |=> mainDacCode == '0)
        else $error("main code not cleared");
    a_cam_fall: assert property ($fell(camStrobeIn) |-> ##[1:2] (pumpMode == PUMP_X1))
        else $error("camera fall kept mode");
    a_shutdown_x1: assert property (shutdown [*2] |-> pumpMode == PUMP_X1)
        else $error("shutdown kept mode");
    a_mode_delay: assert property ($changed(pumpMode) && pumpMode != PUMP_X1
        |-> dropCnt_ff >= SWITCH_CYC - 2)
        else $error("mode step too early");
endmodule
bind led_strobe_dac_pump_ctrl led_strobe_properties i_props(.clk(clk), .sys_rst(sys_rst),
    .mainStrobeIn(mainStrobeIn), .camStrobeIn(camStrobeIn), .mainSinkDropout(mainSinkDropout),
    .camSinkDropout(camSinkDropout), .mainSinkTiedToPump(mainSinkTiedToPump),
    .mainSetResistorLow(mainSetResistorLow), .camSetResistorLow(camSetResistorLow),
    .mainDacCode(mainDacCode), .mainLedSinksEn(mainLedSinksEn), .shutdown(shutdown),
    .overcurrent(overcurrent), .pumpMode(pumpMode), .pumpPhase1(pumpPhase1),
    .pumpPhase2(pumpPhase2));

//--- bench/strobe_host.sv
// Purpose: Host model that strobes the two enable lines.
// Assumes: Two cycles low and two high per pulse, above the minimum width.
// Notes: Lines stay high after the last edge so the counts get latched.
`timescale 1ns/1ps
module strobe_host
(
    input wire logic clk,
    input wire logic start,
    input wire logic stop,
    input wire logic [6:0] mainN,
    input wire logic [3:0] camN,
    output logic mainStrobeIn,
    output logic camStrobeIn,
    output logic done
);
    int i;
    initial
    begin
        mainStrobeIn = 0;
        camStrobeIn = 0;
        done = 0;
        @(posedge clk iff start);
        for (i = 0; i < 2 * mainN; i++)
        begin
            repeat (2) @(posedge clk);
            #1 mainStrobeIn = (i >= 2 * mainN - 1) || !i[0];
            camStrobeIn = (i >= 2 * camN - 1) || !i[0];
        end
        done = 1;
        @(posedge clk iff stop);
        #1 camStrobeIn = 0;
    end
endmodule

//--- bench/tb.sv
// Purpose: Self-checking bench for the strobe DAC and pump control.
// Assumes: The host model strobes; the bench drives the sense inputs.
// Notes: Latch and mode delays are fixed, so the run is long.
`timescale 1ns/1ps
`define CHK(nm, e, g) compares++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end
module tb;
    import led_strobe_pkg::*;
    logic clk = 0, sys_rst = 1, start = 0, stop = 0, mStb, cStb, done, mRes = 0, cRes = 0;
    logic [3:0] drop = 0, tied = 0, mEn, camN;
    logic [5:0] mCode;
    logic [2:0] cCode;
    logic [7:0] strength;
    logic cEn, pEn, rEn, sd, oc, ph1, ph2;
    pump_mode_t mode;
    int n_errors = 0, compares = 0, cyc = 0, seed = 32'hfa8a, k;
    // ------------------------------------------------------------
    // Instances, clock and sequence
    // ------------------------------------------------------------
    strobe_host i_host(.clk(clk), .start(start), .stop(stop), .mainN(7'd70), .camN(camN),
        .mainStrobeIn(mStb), .camStrobeIn(cStb), .done(done));
    led_strobe_dac_pump_ctrl i_dut(.clk(clk), .sys_rst(sys_rst), .mainStrobeIn(mStb),
        .camStrobeIn(cStb), .mainSinkDropout(drop), .camSinkDropout(1'b0),
        .mainSinkTiedToPump(tied), .mainSetResistorLow(mRes), .camSetResistorLow(cRes),
        .mainDacCode(mCode), .camDacCode(cCode), .mainLedSinksEn(mEn), .camLedSinkEn(cEn),
        .pumpEn(pEn), .refEn(rEn), .shutdown(sd), .overcurrent(oc), .pumpMode(mode),
        .pumpPhase1(ph1), .pumpPhase2(ph2), .pumpStrength(strength));
    function automatic logic [5:0] expCode(input int n, input int fs);
        return (n == 0) ? 6'h00 : (n >= fs) ? 6'h01 : 6'(fs + 1 - n);
    endfunction
    task automatic summarize();
        if (n_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial forever #4 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 95000)
        begin
            n_errors++;
            summarize();
        end
    end
    initial
    begin
        camN = 4'd1 + 4'($unsigned($random(seed)) % 7);
        tied = 4'($random(seed)) & 4'he;
        repeat (12) @(posedge clk);
        #1 sys_rst = 0;
        `CHK("shutdown", 1'b1, sd)
        `CHK("mode", PUMP_X1, mode)
        start = 1;
        @(posedge clk);
        #1 start = 0;
        for (k = 0; k < 400 && done !== 1'b1; k++) @(posedge clk);
        repeat (LATCH_CYC - 20) @(posedge clk);
        #1 `CHK("early", 6'h00, mCode)
        for (k = 0; k < REF_CYC + 100 && mCode === 6'h00; k++)
        begin
            @(posedge clk);
            #1;
        end
        `CHK("refDelay", 1'b1, k >= REF_CYC - 300)
        repeat (2) @(posedge clk);
        #1 `CHK("mainCode", expCode(70, 63), mCode)
        `CHK("camCode", 3'(expCode(camN, 7)), cCode)
        `CHK("camEn", 1'b1, cEn)
        `CHK("mainEn", ~tied, mEn)
        `CHK("refEn", 1'b1, rEn)
        drop = 4'h1;
        for (k = 0; k < SWITCH_CYC + 100 && mode === PUMP_X1; k++)
        begin
            @(posedge clk);
            #1;
        end
        `CHK("delay", 1'b1, k >= SWITCH_CYC - 10)
        `CHK("pumpEn", 1'b1, pEn)
        `CHK("mode", PUMP_X15, mode)
        `CHK("ramp", 1'b1, strength < 8'hff)
        drop = 4'h0;
        @(posedge ph1);
        k = cyc;
        @(posedge ph1);
        `CHK("period", 2 * HALF_CYC, cyc - k)
        #1 stop = 1;
        repeat (5) @(posedge clk);
        #1 `CHK("mode", PUMP_X1, mode)
        `CHK("camCode", 3'h0, cCode)
        `CHK("camEn", 1'b0, cEn)
        repeat (20)
        begin
            @(posedge clk);
            #1 {mRes, cRes} = 2'($random(seed));
        end
        @(posedge clk);
        #1 {mRes, cRes} = 2'b10;
        repeat (2) @(posedge clk);
        #1 `CHK("overcurrent", 1'b1, oc)
        `CHK("shutdown", 1'b1, sd)
        `CHK("pumpEn", 1'b0, pEn)
        `CHK("refEn", 1'b0, rEn)
        `CHK("mainEn", 4'h0, mEn)
        `CHK("mode", PUMP_X1, mode)
        summarize();
    end
endmodule
